// file: fep_pkg.sv
// Purpose: shared constants, types and helpers for the phy rx/link block
// Assumes: one 50 MHz system clock, symbols aligned upstream
// Notes: counts are derived from printed times below
package fep_pkg;
  // ==================================================
  // timing
  localparam int CLK_MHZ = 50;
  localparam int SUP_TIME_US = 724;
  localparam int SUP_CYC = SUP_TIME_US * CLK_MHZ;
  localparam int STAB_TIME_US = 500;
  localparam int STAB_CYC = STAB_TIME_US * CLK_MHZ;
  localparam int LOSS_TIME_MS = 100;
  localparam int LOSS_CYC = LOSS_TIME_MS * 1000 * CLK_MHZ;
  localparam int LOCK_IDLES = 30;
  localparam int LP_PASS = 3;
  localparam int LNK_W = 23;
  localparam int SUP_W = 16;
  localparam int RUN_W = 8;
  localparam int LPC_W = 4;
  // ==================================================
  // code groups and receive nibbles
  localparam logic [4:0] CG_I = 5'h1f;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0d;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_DATA [16] = '{5'h1e, 5'h09, 5'h14, 5'h15,
    5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17,
    5'h1a, 5'h1b, 5'h1c, 5'h1d};
  localparam logic [3:0] RXD_LOCK = 4'h2;
  localparam logic [3:0] RXD_LINK = 4'h3;
  localparam logic [3:0] RXD_PREM = 4'h6;
  localparam logic [3:0] RXD_INV = 4'h7;
  localparam logic [3:0] RXD_FALSE = 4'he;
  localparam logic [3:0] RXD_PRE = 4'h5;
  localparam logic [3:0] RXD_ZERO = 4'h0;
  // ==================================================
  // stream cipher
  localparam int TAP_A = 10;
  localparam int TAP_B = 8;
  localparam logic [10:0] LFSR_SEED = 11'h7ff;
  // ==================================================
  // types
  typedef struct packed {
    logic fd100;
    logic hd100;
    logic fd10;
    logic hd10;
  } fep_abil_s;
  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] d;
  } fep_rxm_s;
  typedef enum logic [2:0] {
    RS_IDLE = 3'h0,
    RS_J = 3'h1,
    RS_DATA = 3'h3,
    RS_T = 3'h2,
    RS_FALSE = 3'h6
  } fep_rxst_e;
  typedef enum logic {LK_FAIL = 1'b0, LK_PASS = 1'b1} fep_lk_e;
  // ==================================================
  // helpers
  // advance the 11-stage lfsr by one symbol; new key bits land in [4:0]
  function automatic logic [10:0] lfsr_adv5(input logic [10:0] s);
    logic [10:0] r;
    r = s;
    for (int i = 0; i < 5; i++) begin
      r = {r[9:0], r[TAP_A] ^ r[TAP_B]};
    end
    return r;
  endfunction
  // {valid, nibble}
  function automatic logic [4:0] dec4b(input logic [4:0] cg);
    logic [4:0] r;
    r = {1'b0, RXD_INV};
    for (int i = 0; i < 16; i++) begin
      if (cg == CG_DATA[i]) r = {1'b1, 4'(i)};
    end
    return r;
  endfunction
  // {ok, 100m, full duplex}, highest shared mode first
  function automatic logic [2:0] best_mode(input fep_abil_s c);
    if (c.fd100) return 3'h7;
    else if (c.hd100) return 3'h6;
    else if (c.fd10) return 3'h5;
    else if (c.hd10) return 3'h4;
    return 3'h0;
  endfunction
endpackage

// file: fep_scrambler.sv
// Purpose: transmit stream cipher, one symbol per advance
// Assumes: adv_in pulses once per transmit symbol
// Notes: bypass passes the symbol straight through
`timescale 1ns/1ps
`default_nettype none
module fep_scrambler (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic adv_in,
  input wire logic bypass_in,
  input wire logic [4:0] sym_in,
  output logic [4:0] sym_out
);
  import fep_pkg::*;
  logic [10:0] lfsr_q;
  logic [10:0] lfsr_d;
  logic [4:0] sym_q;
  assign lfsr_d = lfsr_adv5(lfsr_q);
  assign sym_out = sym_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lfsr_q <= LFSR_SEED;
      sym_q <= CG_I;
    end else if (adv_in) begin
      lfsr_q <= lfsr_d;
      sym_q <= bypass_in ? sym_in : sym_in ^ lfsr_d[4:0];
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_scr_key_mix: assert property (adv_in && !bypass_in |=>
    (sym_out ^ $past(sym_in)) == lfsr_q[4:0])
    else $error("scrambled symbol does not match lfsr key");
  a_scr_bypass_pass: assert property (adv_in && bypass_in |=>
    sym_out == $past(sym_in))
    else $error("bypassed symbol altered");
endmodule // fep_scrambler
`default_nettype wire

// file: fep_descrambler.sv
// Purpose: receive descrambler with idle-based lock and supervision
// Assumes: stb_in pulses once per aligned received symbol
// Notes: enable low forces unlock and clears all state
`timescale 1ns/1ps
`default_nettype none
module fep_descrambler #(
  parameter int LOCK_IDLES_P = fep_pkg::LOCK_IDLES,
  parameter int SUP_CYC_P = fep_pkg::SUP_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic stb_in,
  input wire logic [4:0] sym_in,
  output logic [4:0] sym_out,
  output logic vld_out,
  output logic locked_out,
  output logic lost_out
);
  import fep_pkg::*;
  logic [10:0] lfsr_q;
  logic [10:0] nxt;
  logic idle_pred;
  logic locked_q;
  logic [RUN_W-1:0] run_q;
  logic [SUP_W-1:0] sup_q;
  logic [4:0] sym_q;
  logic vld_q;
  logic lost_q;
  logic run_ok;
  assign nxt = lfsr_adv5(lfsr_q);
  // an idle scrambled by the key reads as the key inverted
  assign idle_pred = (sym_in == ~nxt[4:0]);
  assign run_ok = run_q >= RUN_W'(LOCK_IDLES_P);
  assign sym_out = sym_q;
  assign vld_out = vld_q;
  assign locked_out = locked_q;
  assign lost_out = lost_q;
  // ==================================================
  // key tracking and lock
  always_ff @(posedge clk_in) begin
    lost_q <= 1'b0;
    vld_q <= 1'b0;
    if (rst_in || !enable_in) begin
      lfsr_q <= LFSR_SEED;
      locked_q <= 1'b0;
      run_q <= '0;
      sup_q <= '0;
      sym_q <= CG_I;
    end else begin
      if (locked_q && sup_q == '0) begin
        locked_q <= 1'b0;
        lost_q <= 1'b1;
        run_q <= '0;
      end else if (locked_q && run_ok) begin
        sup_q <= SUP_W'(SUP_CYC_P);
      end else if (locked_q) begin
        sup_q <= sup_q - 1'b1;
      end
      if (stb_in) begin
        // unlocked: load the key from the line assuming idle is sent
        lfsr_q <= locked_q ? nxt : {lfsr_q[5:0], ~sym_in};
        run_q <= idle_pred ? (run_ok ? run_q : run_q + 1'b1) : '0;
        sym_q <= sym_in ^ nxt[4:0];
        vld_q <= locked_q;
        if (!locked_q && run_ok) begin
          locked_q <= 1'b1;
          sup_q <= SUP_W'(SUP_CYC_P);
        end
      end
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_lock_needs_run: assert property ($rose(locked_q) |->
    $past(run_q) >= RUN_W'(LOCK_IDLES_P))
    else $error("lock without enough idles");
  a_unlock_link_fail: assert property (!enable_in |=>
    !locked_out && !vld_out)
    else $error("still locked during link failure");
  a_sup_drop_lock: assert property (locked_q && sup_q == '0 |=>
    !locked_q && lost_out)
    else $error("supervision expiry did not drop lock");
  a_no_data_unlocked: assert property (!locked_q |=> !vld_out)
    else $error("data passed while unlocked");
endmodule // fep_descrambler
`default_nettype wire

// file: fep_phy_link.sv
// Purpose: link monitor, carrier/rx valid, collision, mode select, cipher
// Assumes: symbols arrive aligned with a strobe; analog front end external
// Notes: crs and col are registered, so they trail the cause by one clock
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - 100M no signal: link fail, send idle
// - valid signal long enough: link pass
// - 10M link pulses judge link integrity
// - 100M crs rises on receive activity
// - rx valid on start delimiter
// - end delimiter or two idles end frame
// - no start delimiter: false carrier error
// - 10M crs on preamble activity
// - half duplex: crs during own transmit
// - full duplex: crs only from receive
// - half duplex: col when carrier meets transmit
// - negotiation on/off by strap or software
// - advertise four modes, pick highest common
// - tx clock from reference, rx from data
// - 100M transmit scrambled by 11-stage lfsr
// - lock from idle run, no decode unlocked
// - too few idles in interval: unlock
// - link failure forces descrambler unlock
// - 10M bypasses scrambler and descrambler
// - 10M bypasses equalizer and baseline correction
// - lock loss and link fail error codes
// - preamble for delimiter, zeros for end/idle
module fep_phy_link #(
  parameter int STAB_CYC_P = fep_pkg::STAB_CYC,
  parameter int LOSS_CYC_P = fep_pkg::LOSS_CYC,
  parameter int SUP_CYC_P = fep_pkg::SUP_CYC,
  parameter int LOCK_IDLES_P = fep_pkg::LOCK_IDLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic an_strap_in,
  input wire logic an_sw_wr_in,
  input wire logic an_sw_en_in,
  input wire fep_pkg::fep_abil_s adv_in,
  input wire fep_pkg::fep_abil_s lp_abil_in,
  input wire logic lp_valid_in,
  input wire logic force_100_in,
  input wire logic force_fd_in,
  input wire logic sig_det_in,
  input wire logic sig_bad_in,
  input wire logic link_pulse_in,
  input wire logic pre10_in,
  input wire fep_pkg::fep_rxm_s rx10_in,
  input wire logic sym_stb_in,
  input wire logic [4:0] rx_sym_in,
  input wire logic tx_en_in,
  input wire logic [4:0] tx_sym_in,
  output logic crs_out,
  output logic col_out,
  output fep_pkg::fep_rxm_s rxm_out,
  output logic link_pass_out,
  output logic locked_out,
  output logic mode_100_out,
  output logic full_dup_out,
  output logic an_en_out,
  output logic [4:0] tx_sym_out,
  output logic tx_clk_out,
  output logic rx_clk_out,
  output logic eq_byp_out,
  output logic blw_byp_out
);
  import fep_pkg::*;
  // ==================================================
  // declarations
  fep_lk_e link_q;
  logic [LNK_W-1:0] lk_cnt_q;
  logic [LPC_W-1:0] lp_cnt_q;
  logic an_en_q;
  logic strap_done_q;
  logic mode_100_q;
  logic fd_q;
  logic [2:0] res;
  logic tx_clk_q;
  logic rx_clk_q;
  logic byp_q;
  logic [4:0] tx_pick;
  logic ds_en;
  logic [4:0] ds_sym;
  logic ds_vld;
  logic ds_locked;
  logic ds_lost;
  logic rx_run;
  logic idle;
  logic [4:0] dec;
  fep_rxst_e st_q;
  fep_rxst_e st_d;
  logic act_q;
  logic act_d;
  logic pidle_q;
  fep_rxm_s rxm_q;
  fep_rxm_s rxm_d;
  logic crs_q;
  logic col_q;
  logic tx_crs;
  // ==================================================
  // outputs
  assign crs_out = crs_q;
  assign col_out = col_q;
  assign rxm_out = rxm_q;
  assign link_pass_out = (link_q == LK_PASS);
  assign mode_100_out = mode_100_q;
  assign full_dup_out = fd_q;
  assign an_en_out = an_en_q;
  assign tx_clk_out = tx_clk_q;
  assign rx_clk_out = rx_clk_q;
  assign eq_byp_out = byp_q;
  assign blw_byp_out = byp_q;
  // ==================================================
  // link monitor
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      link_q <= LK_FAIL;
      lk_cnt_q <= '0;
      lp_cnt_q <= '0;
    end else if (mode_100_q) begin
      lp_cnt_q <= '0;
      if (sig_det_in && !sig_bad_in) begin
        if (lk_cnt_q >= LNK_W'(STAB_CYC_P)) begin
          link_q <= LK_PASS;
        end else begin
          lk_cnt_q <= lk_cnt_q + 1'b1;
        end
      end else begin
        link_q <= LK_FAIL;
        lk_cnt_q <= '0;
      end
    end else begin
      // 10M: pulses or frames keep the loss timer from running out
      if (link_pulse_in || pre10_in) begin
        lk_cnt_q <= '0;
        if (link_pulse_in && lp_cnt_q < LPC_W'(LP_PASS)) begin
          lp_cnt_q <= lp_cnt_q + 1'b1;
        end
        if ((link_pulse_in && lp_cnt_q >= LPC_W'(LP_PASS - 1)) || pre10_in) begin
          link_q <= LK_PASS;
        end
      end else if (lk_cnt_q >= LNK_W'(LOSS_CYC_P)) begin
        link_q <= LK_FAIL;
        lp_cnt_q <= '0;
      end else begin
        lk_cnt_q <= lk_cnt_q + 1'b1;
      end
    end
  end
  // ==================================================
  // negotiation enable and mode resolution
  assign res = best_mode(adv_in & lp_abil_in);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      an_en_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      // strap caught on the first clock after reset release
      an_en_q <= an_strap_in;
      strap_done_q <= 1'b1;
    end else if (an_sw_wr_in) begin
      an_en_q <= an_sw_en_in;
    end
  end
  // next pages stay a management concern outside this block
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_100_q <= 1'b0;
      fd_q <= 1'b0;
    end else if (!an_en_q) begin
      mode_100_q <= force_100_in;
      fd_q <= force_fd_in;
    end else if (lp_valid_in && res[2]) begin
      mode_100_q <= res[1];
      fd_q <= res[0];
    end
  end
  // ==================================================
  // clocks and analog bypass
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_clk_q <= 1'b0;
      rx_clk_q <= 1'b0;
      byp_q <= 1'b1;
    end else begin
      tx_clk_q <= ~tx_clk_q;
      if (sym_stb_in) begin
        rx_clk_q <= ~rx_clk_q;
      end
      byp_q <= ~mode_100_q;
    end
  end
  // ==================================================
  // transmit path
  // only idles leave while the 100M link is down
  assign tx_pick = (mode_100_q && link_q == LK_FAIL) ? CG_I : tx_sym_in;
  fep_scrambler u_scr (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .adv_in(tx_clk_q),
    .bypass_in(~mode_100_q),
    .sym_in(tx_pick),
    .sym_out(tx_sym_out)
  );
  // ==================================================
  // descrambler
  assign ds_en = mode_100_q && (link_q == LK_PASS);
  fep_descrambler #(
    .LOCK_IDLES_P(LOCK_IDLES_P),
    .SUP_CYC_P(SUP_CYC_P)
  ) u_dscr (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .enable_in(ds_en),
    .stb_in(sym_stb_in),
    .sym_in(rx_sym_in),
    .sym_out(ds_sym),
    .vld_out(ds_vld),
    .locked_out(ds_locked),
    .lost_out(ds_lost)
  );
  assign locked_out = ds_locked;
  // ==================================================
  // receive framing
  assign rx_run = ds_en && ds_locked;
  assign idle = (ds_sym == CG_I);
  assign dec = dec4b(ds_sym);
  always_comb begin
    st_d = st_q;
    act_d = act_q;
    rxm_d = rxm_q;
    if (!mode_100_q) begin
      st_d = RS_IDLE;
      act_d = pre10_in;
      rxm_d = rx10_in;
    end else if (!rx_run) begin
      st_d = RS_IDLE;
      act_d = 1'b0;
      rxm_d = '0;
      // one error nibble when a frame is cut short
      if (st_q != RS_IDLE || ds_lost) begin
        rxm_d.er = 1'b1;
        rxm_d.d = (link_q == LK_PASS) ? RXD_LOCK : RXD_LINK;
      end
    end else if (ds_vld) begin
      unique case (st_q)
        RS_IDLE: begin
          rxm_d = '0;
          if (!idle) begin
            act_d = 1'b1;
            if (ds_sym == CG_J) begin
              st_d = RS_J;
            end else begin
              st_d = RS_FALSE;
              rxm_d.er = 1'b1;
              rxm_d.d = RXD_FALSE;
            end
          end
        end
        RS_J: begin
          if (ds_sym == CG_K) begin
            st_d = RS_DATA;
            rxm_d.dv = 1'b1;
            rxm_d.er = 1'b0;
            rxm_d.d = RXD_PRE;
          end else begin
            st_d = RS_FALSE;
            rxm_d.er = 1'b1;
            rxm_d.d = RXD_FALSE;
          end
        end
        RS_DATA: begin
          rxm_d.dv = 1'b1;
          rxm_d.er = 1'b0;
          rxm_d.d = RXD_ZERO;
          if (idle && pidle_q) begin
            st_d = RS_IDLE;
            act_d = 1'b0;
            rxm_d = '0;
          end else if (ds_sym == CG_T) begin
            st_d = RS_T;
          end else if (!idle) begin
            rxm_d.er = ~dec[4];
            rxm_d.d = dec[3:0];
          end
        end
        RS_T: begin
          if (ds_sym == CG_R) begin
            st_d = RS_IDLE;
            act_d = 1'b0;
            rxm_d = '0;
          end else begin
            // end delimiter broken off
            st_d = RS_DATA;
            rxm_d.er = 1'b1;
            rxm_d.d = RXD_PREM;
          end
        end
        RS_FALSE: begin
          if (idle && pidle_q) begin
            st_d = RS_IDLE;
            act_d = 1'b0;
            rxm_d = '0;
          end
        end
        default: begin
          st_d = RS_IDLE;
          act_d = 1'b0;
          rxm_d = '0;
        end
      endcase
    end
  end
  // ==================================================
  // receive, carrier and collision registers
  assign tx_crs = !fd_q && tx_en_in && link_q == LK_PASS;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= RS_IDLE;
      act_q <= 1'b0;
      pidle_q <= 1'b0;
      rxm_q <= '0;
      crs_q <= 1'b0;
      col_q <= 1'b0;
    end else begin
      st_q <= st_d;
      act_q <= act_d;
      rxm_q <= rxm_d;
      if (ds_vld) begin
        pidle_q <= idle;
      end
      crs_q <= act_d || tx_crs;
      col_q <= !fd_q && tx_en_in && act_d;
    end
  end
  // ==================================================
  // checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_fail_sends_idle: assert property (mode_100_q && link_q == LK_FAIL && tx_clk_q
    |=> (tx_sym_out ^ u_scr.lfsr_q[4:0]) == CG_I)
    else $error("non-idle chosen while link failed");
  a_pass_after_stab: assert property ($rose(link_q) && $past(mode_100_q)
    |-> $past(lk_cnt_q) >= LNK_W'(STAB_CYC_P))
    else $error("link pass too early");
  a_loss_fails_10m: assert property (!mode_100_q && !link_pulse_in
    && !pre10_in && lk_cnt_q >= LNK_W'(LOSS_CYC_P) |=> link_q == LK_FAIL)
    else $error("10M link kept without pulses");
  a_crs_on_activity: assert property (mode_100_q && rx_run && ds_vld
    && st_q == RS_IDLE && !idle |=> crs_out)
    else $error("crs missed receive activity");
  a_dv_on_k: assert property (mode_100_q && rx_run && ds_vld
    && st_q == RS_J && ds_sym == CG_K |=> rxm_out.dv && rxm_out.d == RXD_PRE)
    else $error("rx valid not raised on delimiter");
  a_end_drops_both: assert property (mode_100_q && rx_run && ds_vld
    && st_q == RS_T && ds_sym == CG_R && !tx_crs |=> !crs_out && !rxm_out.dv)
    else $error("frame not closed on end delimiter");
  a_false_carrier: assert property (mode_100_q && rx_run && ds_vld
    && st_q == RS_J && ds_sym != CG_K
    |=> rxm_out.er && !rxm_out.dv && rxm_out.d == RXD_FALSE)
    else $error("false carrier not flagged");
  a_crs_preamble_10m: assert property (!mode_100_q && pre10_in |=> crs_out)
    else $error("10M crs missed preamble");
  a_crs_own_tx: assert property (tx_crs |=> crs_out)
    else $error("half duplex crs missed transmit");
  a_fd_crs_rx_only: assert property (fd_q && !act_d |=> !crs_out)
    else $error("full duplex crs from transmit");
  a_col_half: assert property (!fd_q && tx_en_in && act_d |=> col_out)
    else $error("collision not flagged");
  a_an_highest: assert property (an_en_q && lp_valid_in
    && adv_in.fd100 && lp_abil_in.fd100 |=> mode_100_q && fd_q)
    else $error("highest common mode not chosen");
  a_bypass_10m: assert property (!mode_100_q ##1 !mode_100_q
    |=> eq_byp_out && blw_byp_out)
    else $error("10M bypass not active");
  a_lock_loss_code: assert property (mode_100_q && ds_lost
    && link_q == LK_PASS |=> rxm_out.er && rxm_out.d == RXD_LOCK)
    else $error("lock loss code missing");
  c_frame_valid: cover property (rxm_out.dv ##1 !rxm_out.dv);
  c_collision: cover property (col_out);
  c_lock_lost: cover property ($fell(locked_out));
endmodule // fep_phy_link
`default_nettype wire

// file: fep_lp_model.sv
// Purpose: far-end line model, scrambles plain code groups
// Assumes: req_in pulses once per symbol, from the bench
// Notes: seed value is arbitrary; any nonzero state works
`timescale 1ns/1ps
`default_nettype none
module fep_lp_model #(
  parameter logic [10:0] SEED_P = 11'h5a3
) (
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic [4:0] plain_in,
  output logic stb_out,
  output logic [4:0] sym_out
);
  // ==========================
  // cipher state
  logic [10:0] key_q;
  logic [10:0] key_d;
  always_comb begin
    key_d = key_q;
    for (int i = 0; i < 5; i++) begin
      key_d = {key_d[9:0], key_d[10] ^ key_d[8]};
    end
  end
  initial begin
    key_q = SEED_P;
    stb_out = 1'b0;
    sym_out = 5'h00;
  end
  // stale symbol is inverted so nothing latches an old value by luck
  always @(posedge clk_in) begin
    stb_out <= req_in;
    if (req_in) begin
      key_q <= key_d;
      sym_out <= plain_in ^ key_d[4:0];
    end else if (stb_out) begin
      sym_out <= ~sym_out;
    end
  end
endmodule // fep_lp_model
`default_nettype wire

// file: testbench.sv
// Purpose: self-checking bench for the phy rx/link block
// Assumes: one symbol per six clocks through the line model
// Notes: long counts are shortened through parameters
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fep_pkg::*;
  // ==========================
  // signals
  logic clk_in, rst_in, an_wr, an_en, lpv, f100, ffd, sdet, sbad, lpul, req, txen, watch;
  fep_abil_s adv, lpab, c;
  logic [4:0] plain, txs, rsym, tso;
  logic strap, pre10, txc, rxc, t;
  logic stb, crs, col, lnk, lck, m100, fd, ane, eqb, blb;
  logic [2:0] dly;
  logic [3:0] n;
  fep_rxm_s rxm, r10;
  fep_rxm_s exp_q[$];
  int error_cnt, samples_checked, cyc;
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  fep_phy_link #(.STAB_CYC_P(20), .LOSS_CYC_P(200), .SUP_CYC_P(300), .LOCK_IDLES_P(12)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .an_strap_in(strap), .an_sw_wr_in(an_wr),
    .an_sw_en_in(an_en), .adv_in(adv), .lp_abil_in(lpab), .lp_valid_in(lpv),
    .force_100_in(f100), .force_fd_in(ffd), .sig_det_in(sdet), .sig_bad_in(sbad),
    .link_pulse_in(lpul), .pre10_in(pre10), .rx10_in(r10), .sym_stb_in(stb),
    .rx_sym_in(rsym), .tx_en_in(txen), .tx_sym_in(txs), .crs_out(crs), .col_out(col),
    .rxm_out(rxm), .link_pass_out(lnk), .locked_out(lck), .mode_100_out(m100),
    .full_dup_out(fd), .an_en_out(ane), .tx_sym_out(tso), .tx_clk_out(txc),
    .rx_clk_out(rxc), .eq_byp_out(eqb), .blw_byp_out(blb));
  fep_lp_model lp (.clk_in(clk_in), .req_in(req), .plain_in(plain), .stb_out(stb),
    .sym_out(rsym));
  // ==========================
  // tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic snd(input logic [4:0] p);
    @(negedge clk_in);
    req = 1'b1;
    plain = p;
    @(negedge clk_in);
    req = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask
  task automatic idles(input int k);
    repeat (k) snd(CG_I);
  endtask
  // line idles are scrambled: rebuild the key from three symbols, predict the fourth
  task automatic txidle();
    logic [4:0] g[4];
    logic [10:0] s;
    for (int i = 0; i < 4; i++) begin
      g[i] = tso;
      repeat (2) @(negedge clk_in);
    end
    s = ~{g[0][0], g[1], g[2]};
    repeat (5) s = {s[9:0], s[10] ^ s[8]};
    chk({7'h0, |(~{g[0], g[1], g[2]})}, 8'h01);
    chk({3'h0, g[3]}, {3'h0, ~s[4:0]});
  endtask
  task automatic conclude();
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================
  // watcher: one decision per strobe, settled three edges later
  always @(posedge clk_in) begin
    dly <= {dly[1:0], stb};
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      error_cnt++;
      conclude();
    end else if (dly[2] && watch && (rxm.dv || rxm.er)) begin
      if (exp_q.size() == 0) chk({2'h0, rxm}, 8'hff);
      else chk({2'h0, rxm}, {2'h0, exp_q.pop_front()});
    end
  end
  // ==========================
  // main sequence
  initial begin
    void'($urandom(32'h4c6ee079));
    {an_wr, an_en, lpv, f100, ffd, sdet, sbad, lpul, req, txen, watch, strap, pre10} = '0;
    adv = '0;
    r10 = '0;
    lpab = '0;
    plain = CG_I;
    txs = 5'h15;
    rst_in = 1'b1;
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clk_in);
    chk({6'h0, eqb, blb}, 8'h03);
    t = txc;
    @(negedge clk_in);
    chk({7'h0, txc ^ t}, 8'h01);
    repeat (3) begin
      lpul = 1'b1;
      @(negedge clk_in);
      lpul = 1'b0;
      repeat (3) @(negedge clk_in);
    end
    chk({7'h0, lnk}, 8'h01);
    chk({3'h0, tso}, 8'h15);
    pre10 = 1'b1;
    r10 = 6'($urandom);
    repeat (2) @(negedge clk_in);
    chk({1'b0, crs, rxm}, {2'b01, r10});
    pre10 = 1'b0;
    f100 = 1'b1;
    repeat (4) @(negedge clk_in);
    chk({6'h0, eqb, blb}, 8'h00);
    txidle();
    sdet = 1'b1;
    repeat (18) @(negedge clk_in);
    chk({7'h0, lnk}, 8'h00);
    repeat (6) @(negedge clk_in);
    chk({7'h0, lnk}, 8'h01);
    txen = 1'b1;
    repeat (3) @(negedge clk_in);
    chk({7'h0, crs}, 8'h01);
    ffd = 1'b1;
    repeat (3) @(negedge clk_in);
    chk({7'h0, crs}, 8'h00);
    ffd = 1'b0;
    t = rxc;
    snd(CG_I);
    chk({7'h0, rxc ^ t}, 8'h01);
    idles(20);
    chk({7'h0, lck}, 8'h01);
    watch = 1'b1;
    snd(CG_J);
    chk({7'h0, col}, 8'h01);
    exp_q.push_back({1'b1, 1'b0, RXD_PRE});
    snd(CG_K);
    repeat (6) begin
      n = 4'($urandom);
      exp_q.push_back({1'b1, 1'b0, n});
      snd(CG_DATA[n]);
    end
    exp_q.push_back({1'b1, 1'b0, 4'h0});
    snd(CG_T);
    txen = 1'b0;
    snd(CG_R);
    snd(CG_I);
    chk({7'h0, crs}, 8'h00);
    exp_q.push_back({1'b0, 1'b1, 4'he});
    snd(CG_DATA[3]);
    watch = 1'b0;
    idles(4);
    chk({7'h0, crs}, 8'h00);
    snd(CG_J);
    watch = 1'b1;
    exp_q.push_back({1'b0, 1'b1, 4'he});
    snd(CG_DATA[3]);
    watch = 1'b0;
    idles(4);
    chk({7'h0, crs}, 8'h00);
    chk(8'(exp_q.size()), 8'h00);
    repeat (70) snd(CG_DATA[4'($urandom)]);
    chk({7'h0, lck}, 8'h00);
    idles(20);
    chk({7'h0, lck}, 8'h01);
    idles(60);
    chk({7'h0, lck}, 8'h01);
    sbad = 1'b1;
    repeat (4) @(negedge clk_in);
    chk({6'h0, lnk, lck}, 8'h00);
    txidle();
    an_en = 1'b1;
    an_wr = 1'b1;
    @(negedge clk_in);
    an_wr = 1'b0;
    lpv = 1'b1;
    repeat (8) begin
      adv = 4'($urandom) | 4'h1;
      lpab = 4'($urandom) | 4'h1;
      c = adv & lpab;
      repeat (4) @(negedge clk_in);
      chk({5'h0, ane, m100, fd}, {6'h01, c.fd100 | c.hd100,
        c.fd100 | (!c.hd100 & c.fd10)});
    end
    an_en = 1'b0;
    an_wr = 1'b1;
    f100 = 1'b0;
    ffd = 1'b1;
    @(negedge clk_in);
    an_wr = 1'b0;
    repeat (4) @(negedge clk_in);
    chk({5'h0, ane, m100, fd}, 8'h01);
    strap = 1'b1;
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk({6'h0, ane, lnk}, 8'h02);
    conclude();
  end
endmodule // testbench
`default_nettype wire
